/* rtl/ecpbh_host.sv */
// host end of the ecp interlocked byte handshake, forward and reverse
//
// Overview of operation
// - forward data: drive byte, hostack high
// - then drive hostclk low: byte valid
// - on periphack high, hostclk back high
// - forward command: same exchange, hostack low
// - reverse start: drive reverse request low
// - on periphclk low, raise hostack
// - latch byte and type on periphclk rise
// - after periphclk high, drop hostack
// - hold 1284 active high in mode
// - strobe=hostclk, autofeed=hostack, ack/busy inputs
`include "ecpbh_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ecpbh_host (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // user side
    input  wire logic                     mode_en,
    input  wire logic                     fwd_valid,
    input  wire logic [`ECPBH_DATA_W-1:0] fwd_data,
    input  wire logic                     fwd_is_cmd,
    output logic                          fwd_ready,
    input  wire logic                     rev_enable,
    output logic                          rev_valid,
    output logic [`ECPBH_DATA_W-1:0]      rev_data,
    output logic                          rev_is_cmd,
    output logic                          periph_req,
    // link pins
    output logic                          strobe_n_o,
    output logic                          autofd_n_o,
    output logic                          select_in_n_o,
    output logic                          init_n_o,
    input  wire logic                     ack_n_i,
    input  wire logic                     busy_i,
    input  wire logic                     paper_end_i,
    input  wire logic                     error_n_i,
    input  wire logic [`ECPBH_DATA_W-1:0] pd_i,
    output logic [`ECPBH_DATA_W-1:0]      pd_o,
    output logic                          pd_oe
);
    ecpbh_pkg::ecpbh_state_t state_reg;
    logic [`ECPBH_CNT_W-1:0] cnt_reg;
    logic                    periph_clk_d_reg;

    // pin naming per mode: hostclk on strobe, hostack on autofeed
    logic periph_clk;
    logic periph_ack;
    logic ack_reverse_n;
    assign periph_clk    = ack_n_i;
    assign periph_ack    = busy_i;
    assign ack_reverse_n = paper_end_i;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_clk_d_reg <= 1'b1;
            periph_req       <= 1'b0;
        end else begin
            periph_clk_d_reg <= periph_clk;
            periph_req       <= mode_en & ~error_n_i;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= ecpbh_pkg::ECPBH_IDLE;
            cnt_reg       <= '0;
            strobe_n_o    <= 1'b1;
            autofd_n_o    <= 1'b0;
            select_in_n_o <= 1'b0;
            init_n_o      <= 1'b1;
            pd_o          <= 8'h00;
            pd_oe         <= 1'b0;
            fwd_ready     <= 1'b0;
            rev_valid     <= 1'b0;
            rev_data      <= 8'h00;
            rev_is_cmd    <= 1'b0;
        end else begin
            fwd_ready     <= 1'b0;
            rev_valid     <= 1'b0;
            select_in_n_o <= mode_en;
            case (state_reg)
                ecpbh_pkg::ECPBH_IDLE: begin
                    if (mode_en && rev_enable) begin
                        pd_oe     <= 1'b0;
                        state_reg <= ecpbh_pkg::ECPBH_R_TURN;
                    end else if (mode_en && fwd_valid && !periph_ack) begin
                        // hostclk high and periphack low here
                        pd_o       <= fwd_data;
                        pd_oe      <= 1'b1;
                        autofd_n_o <= ~fwd_is_cmd;
                        fwd_ready  <= 1'b1;
                        cnt_reg    <= `ECPBH_CNT_W'(`ECPBH_SETUP_CYC);
                        state_reg  <= ecpbh_pkg::ECPBH_F_SETUP;
                    end
                end
                ecpbh_pkg::ECPBH_F_SETUP: begin
                    if (cnt_reg > `ECPBH_CNT_W'(1)) begin
                        cnt_reg <= cnt_reg - `ECPBH_CNT_W'(1);
                    end else begin
                        strobe_n_o <= 1'b0;
                        state_reg  <= ecpbh_pkg::ECPBH_F_STROBE;
                    end
                end
                ecpbh_pkg::ECPBH_F_STROBE: begin
                    if (periph_ack) begin
                        strobe_n_o <= 1'b1;
                        state_reg  <= ecpbh_pkg::ECPBH_F_WAITLOW;
                    end
                end
                ecpbh_pkg::ECPBH_F_WAITLOW: begin
                    if (!periph_ack) begin
                        state_reg <= ecpbh_pkg::ECPBH_IDLE;
                    end
                end
                ecpbh_pkg::ECPBH_R_TURN: begin
                    autofd_n_o <= 1'b0;
                    init_n_o   <= 1'b0;
                    state_reg  <= ecpbh_pkg::ECPBH_R_WAITGRANT;
                end
                ecpbh_pkg::ECPBH_R_WAITGRANT: begin
                    if (!rev_enable || !mode_en) begin
                        state_reg <= ecpbh_pkg::ECPBH_R_ENDREV;
                    end else if (!ack_reverse_n) begin
                        state_reg <= ecpbh_pkg::ECPBH_R_WAITCLK;
                    end
                end
                ecpbh_pkg::ECPBH_R_WAITCLK: begin
                    if (!periph_clk) begin
                        autofd_n_o <= 1'b1;
                        state_reg  <= ecpbh_pkg::ECPBH_R_WAITHIGH;
                    end else if (!rev_enable || !mode_en) begin
                        state_reg <= ecpbh_pkg::ECPBH_R_ENDREV;
                    end
                end
                ecpbh_pkg::ECPBH_R_WAITHIGH: begin
                    if (periph_clk && !periph_clk_d_reg) begin
                        rev_data   <= pd_i;
                        rev_is_cmd <= ~periph_ack;
                        rev_valid  <= 1'b1;
                        autofd_n_o <= 1'b0;
                        state_reg  <= ecpbh_pkg::ECPBH_R_WAITCLK;
                    end
                end
                ecpbh_pkg::ECPBH_R_ENDREV: begin
                    init_n_o <= 1'b1;
                    if (ack_reverse_n) begin
                        state_reg <= ecpbh_pkg::ECPBH_IDLE;
                    end
                end
                default: state_reg <= ecpbh_pkg::ECPBH_IDLE;
            endcase
        end
    end

    // rising periphclk edge seen only once the raw level is back high
    a_rev_latch_edge: assert property (@(posedge clk) disable iff (!rst_n)
        rev_valid |-> $past(periph_clk) && !$past(periph_clk_d_reg) && !autofd_n_o)
        else $error("reverse byte latched off the periphclk rise");
    a_strobe_release: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ecpbh_pkg::ECPBH_F_STROBE && periph_ack) |=> strobe_n_o)
        else $error("hostclk not returned high after periphack");
    a_strobe_setup: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(strobe_n_o) |-> pd_oe && $stable(pd_o) && $stable(autofd_n_o))
        else $error("hostclk fell while forward byte changing");
    // two setup cycles between taking the byte and the hostclk fall
    a_setup_time: assert property (@(posedge clk) disable iff (!rst_n)
        fwd_ready |-> strobe_n_o ##1 strobe_n_o ##1 !strobe_n_o)
        else $error("hostclk fall not two cycles after byte taken");
    a_data_stable: assert property (@(posedge clk) disable iff (!rst_n)
        ($changed(pd_o) && pd_oe) |-> $past(strobe_n_o) && !$past(periph_ack))
        else $error("forward byte changed mid handshake");
    a_hostack_data: assert property (@(posedge clk) disable iff (!rst_n)
        (fwd_ready && !$past(fwd_is_cmd)) |-> autofd_n_o && pd_oe && pd_o == $past(fwd_data))
        else $error("forward data byte not presented with hostack high");
    a_fwd_type: assert property (@(posedge clk) disable iff (!rst_n)
        fwd_ready |-> autofd_n_o == ~$past(fwd_is_cmd))
        else $error("forward cycle type wrong on hostack");
    // no new byte taken until periphack is seen low again
    a_fwd_refused: assert property (@(posedge clk) disable iff (!rst_n)
        fwd_ready |-> !$past(periph_ack) && $past(state_reg) == ecpbh_pkg::ECPBH_IDLE)
        else $error("forward byte taken while periphack high");
    a_fwd_waitlow: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ecpbh_pkg::ECPBH_F_WAITLOW && periph_ack) |=> strobe_n_o && state_reg == ecpbh_pkg::ECPBH_F_WAITLOW)
        else $error("forward handshake left before periphack low");
    a_rev_request: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ecpbh_pkg::ECPBH_R_TURN) |=> !init_n_o)
        else $error("reverse request not driven low");
    a_rev_release: assert property (@(posedge clk) disable iff (!rst_n)
        !init_n_o |-> !pd_oe)
        else $error("data lines driven during reverse request");
    a_hostack_rise: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ecpbh_pkg::ECPBH_R_WAITCLK && !periph_clk) |=> autofd_n_o)
        else $error("hostack not raised on periphclk low");
    a_hostack_drop: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ecpbh_pkg::ECPBH_R_WAITHIGH && periph_clk && !periph_clk_d_reg) |=> !autofd_n_o && rev_valid)
        else $error("hostack not dropped after periphclk rise");
    a_active_line: assert property (@(posedge clk) disable iff (!rst_n)
        mode_en |=> select_in_n_o)
        else $error("1284 active not held high in mode");
    a_rev_cmd_type: assert property (@(posedge clk) disable iff (!rst_n)
        rev_valid |-> rev_is_cmd == ~$past(periph_ack))
        else $error("reverse cycle type recorded wrongly");
    // first cycle after a reset release is left out: the flop held its reset value
    a_periph_req: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> periph_req == $past(mode_en && !error_n_i))
        else $error("peripheral request not passed through");

endmodule : ecpbh_host

`default_nettype wire

/* shared/ecpbh_cfg.svh */
// timing counts and field layout for the ecp byte handshake
`ifndef ECPBH_CFG_SVH
`define ECPBH_CFG_SVH

`define ECPBH_SETUP_NS      10
`define ECPBH_CLK_NS        5
`define ECPBH_SETUP_CYC     ((`ECPBH_SETUP_NS + `ECPBH_CLK_NS - 1) / `ECPBH_CLK_NS)
`define ECPBH_CNT_W         4
`define ECPBH_DATA_W        8

`endif

/* shared/ecpbh_pkg.sv */
// types for the ecp byte handshake
`default_nettype none
package ecpbh_pkg;
    typedef enum logic [3:0] {
        ECPBH_IDLE,
        ECPBH_F_SETUP,
        ECPBH_F_STROBE,
        ECPBH_F_RELEASE,
        ECPBH_F_WAITLOW,
        ECPBH_R_TURN,
        ECPBH_R_WAITGRANT,
        ECPBH_R_WAITCLK,
        ECPBH_R_WAITHIGH,
        ECPBH_R_ENDREV
    } ecpbh_state_t;
endpackage : ecpbh_pkg
`default_nettype wire

/* tb/ecp_byte_handshake_tb.sv */
// self-checking bench for the ecp host handshake
`timescale 1ns/1ps
`default_nettype none
module ecp_byte_handshake_tb;
    logic clk, rst_n, mode_en, fwd_valid, fwd_is_cmd, rev_enable, error_n_i;
    logic fwd_ready, rev_valid, rev_is_cmd, periph_req, strobe_n_o, autofd_n_o;
    logic select_in_n_o, init_n_o, pd_oe, busy_i, ack_n_i, paper_end_i;
    logic [7:0] fwd_data, rev_data, pd_o, pd_i;
    logic [8:0] got;
    int         got_cnt, failures, comparisons, n, i, c0;
    // type bit above the byte
    logic [8:0] rows [4] = '{9'h0a5, 9'h15a, 9'h100, 9'h0ff};
    ecpbh_host dut_u (.clk(clk), .rst_n(rst_n), .mode_en(mode_en), .fwd_valid(fwd_valid),
        .fwd_data(fwd_data), .fwd_is_cmd(fwd_is_cmd), .fwd_ready(fwd_ready),
        .rev_enable(rev_enable), .rev_valid(rev_valid), .rev_data(rev_data),
        .rev_is_cmd(rev_is_cmd), .periph_req(periph_req), .strobe_n_o(strobe_n_o),
        .autofd_n_o(autofd_n_o), .select_in_n_o(select_in_n_o), .init_n_o(init_n_o),
        .ack_n_i(ack_n_i), .busy_i(busy_i), .paper_end_i(paper_end_i),
        .error_n_i(error_n_i), .pd_i(pd_i), .pd_o(pd_o), .pd_oe(pd_oe));
    ecpbh_periph peri_u (.clk(clk), .strobe_n_o(strobe_n_o), .autofd_n_o(autofd_n_o),
        .init_n_o(init_n_o), .pd_o(pd_o), .busy_i(busy_i), .ack_n_i(ack_n_i),
        .paper_end_i(paper_end_i), .pd_i(pd_i), .got(got), .got_cnt(got_cnt));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic tally_and_finish;
        failures += peri_u.stalls;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic tmo(input int k);
        if (k >= 50) begin
            failures++;
            tally_and_finish();
        end
    endtask : tmo
    initial begin
        {rst_n, mode_en, fwd_valid, fwd_is_cmd, rev_enable, fwd_data} = '0;
        {error_n_i, failures, comparisons} = '0;
        error_n_i = 1'b1;
        repeat (16) @(posedge clk);
        #1 chk({strobe_n_o, init_n_o, pd_oe, select_in_n_o}, 9'h00c);
        rst_n = 1'b1;
        mode_en = 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(select_in_n_o, 9'h001);
        for (i = 0; i < 4; i++) begin
            c0 = got_cnt;
            {fwd_is_cmd, fwd_data} = rows[i];
            fwd_valid = 1'b1;
            for (n = 0; fwd_ready !== 1'b1 && n < 50; n++) @(posedge clk) #1;
            tmo(n);
            fwd_valid = 1'b0;
            for (n = 0; got_cnt == c0 && n < 50; n++) @(posedge clk) #1;
            tmo(n);
            chk(got, rows[i]);
        end
        error_n_i = 1'b0;
        repeat (3) @(posedge clk) #1;
        chk(periph_req, 9'h001);
        rev_enable = 1'b1;
        for (n = 0; init_n_o !== 1'b0 && n < 50; n++) @(posedge clk) #1;
        tmo(n);
        chk({pd_oe, autofd_n_o}, 9'h000);
        for (i = 0; i < 2; i++) begin
            fork
                peri_u.send(rows[i][7:0], rows[i][8]);
                for (n = 0; rev_valid !== 1'b1 && n < 50; n++) @(posedge clk) #1;
            join
            tmo(n);
            chk({rev_is_cmd, rev_data}, rows[i]);
            chk(autofd_n_o, 9'h000);
        end
        rev_enable = 1'b0;
        for (n = 0; init_n_o !== 1'b1 && n < 50; n++) @(posedge clk) #1;
        tmo(n);
        rst_n = 1'b0;
        #1 chk({strobe_n_o, init_n_o, pd_oe}, 9'h006);
        tally_and_finish();
    end
endmodule : ecp_byte_handshake_tb
`default_nettype wire

/* tb/ecpbh_periph.sv */
// behavioural peripheral at the far end of the ecp link
`timescale 1ns/1ps
`default_nettype none
module ecpbh_periph (
    // clock
    input  wire logic       clk,
    // host pins
    input  wire logic       strobe_n_o,
    input  wire logic       autofd_n_o,
    input  wire logic       init_n_o,
    input  wire logic [7:0] pd_o,
    // peripheral pins
    output logic            busy_i,
    output logic            ack_n_i,
    output logic            paper_end_i,
    output logic [7:0]      pd_i,
    // last forward byte, type above data
    output logic [8:0]      got,
    output int              got_cnt
);
    // handshakes that the host never answered
    int stalls;
    initial begin
        busy_i = 1'b0;
        ack_n_i = 1'b1;
        paper_end_i = 1'b1;
        pd_i = 8'h00;
        got_cnt = 0;
        stalls = 0;
    end
    always @(posedge clk) if (init_n_o === 1'b1) busy_i <= #1 !strobe_n_o;
    always @(posedge strobe_n_o) if (init_n_o === 1'b1) begin
        got = {~autofd_n_o, pd_o};
        got_cnt++;
    end
    always @(posedge clk) paper_end_i <= #1 init_n_o;
    task automatic send(input logic [7:0] b, input logic cmd);
        int n;
        @(posedge clk) #1;
        pd_i = b;
        busy_i = ~cmd;
        @(posedge clk) #1;
        ack_n_i = 1'b0;
        n = 0;
        while (autofd_n_o !== 1'b1 && n < 40) begin @(posedge clk); n++; end
        if (n >= 40) stalls++;
        #1 ack_n_i = 1'b1;
        n = 0;
        while (autofd_n_o !== 1'b0 && n < 40) begin @(posedge clk); n++; end
        if (n >= 40) stalls++;
        #1 pd_i = ~b;
    endtask : send
endmodule : ecpbh_periph
`default_nettype wire
